// ---- bcl_break_control.sv ----
// Two-channel break controller with APB registers and interrupt.
// Contract
// - Channel B bus match sets flag bit 12; writing 0 clears it.
// - Bit 11 turns branch trace off at 0 and on at 1, reset 0.
// - Bit 10 places channel A fetch break before (0) or after (1) execution.
// - Bit 6 places channel B fetch break before (0) or after (1) execution.
// - Bit 7 adds the data value to channel A's match when 1.
// - Bit 5 adds the data value to channel B's match when 1.
// - Bit 3 chooses independent (0) or chained A-then-B (1) matching.
// - Bit 0 applies a match-count break to channel B only.
// - Reserved bits 9, 8, 4, 2, 1 read 0 and software writes only 0.
// - With count break each B match decrements a nonzero count; break at count one.
// - A user break disable bit of 1 suppresses that channel's break request.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module bcl_break_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core bus cycles
    input wire bcl_pkg::bcl_bus_cycle_s busCycle,
    input wire logic fetchRetire,
    // Break outputs
    output logic userBreak,
    output logic branchTraceEn,
    output logic irq
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [31:0] breakControl;
        logic [11:0] matchCount;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        logic chainArmed;
        bcl_pkg::bcl_cmp_s cmpA;
        bcl_pkg::bcl_cmp_s cmpB;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic userBreak;
        logic irq;
    } bcl_state_s;

    bcl_state_s state_q;
    bcl_state_s state_d;
    logic hitA;
    logic hitB;

    // ****************************************************************
    // Channel comparators
    // ****************************************************************
    bcl_chan_match chanA (
        .clk(clk),
        .rst_b(rst_b),
        .cmpVal(state_q.cmpA),
        .dataEn(state_q.breakControl[bcl_pkg::DATA_EN_A_BIT]),
        .timingAfter(state_q.breakControl[bcl_pkg::TIMING_A_BIT]),
        .cyc(busCycle),
        .fetchRetire(fetchRetire),
        .hit(hitA)
    );

    bcl_chan_match chanB (
        .clk(clk),
        .rst_b(rst_b),
        .cmpVal(state_q.cmpB),
        .dataEn(state_q.breakControl[bcl_pkg::DATA_EN_B_BIT]),
        .timingAfter(state_q.breakControl[bcl_pkg::TIMING_B_BIT]),
        .cyc(busCycle),
        .fetchRetire(fetchRetire),
        .hit(hitB)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic chained;
        logic countEn;
        logic bQualified;
        logic bBreak;
        logic aBreak;
        logic setFlagB;
        logic [1:0] irqSet;
        logic access;
        logic wr;
        state_d = state_q;
        bQualified = 1'b0;
        bBreak = 1'b0;
        aBreak = 1'b0;
        setFlagB = 1'b0;
        irqSet = 2'h0;
        chained = state_q.breakControl[bcl_pkg::CHAINED_BIT];
        countEn = state_q.breakControl[bcl_pkg::COUNT_EN_BIT];
        access = psel && penable && !state_q.ready;
        wr = access && pwrite;
        state_d.ready = access;
        state_d.slverr = 1'b0;

        // Channel B is qualified only after A in chained mode.
        bQualified = hitB && (!chained || state_q.chainArmed);
        setFlagB = bQualified;
        aBreak = hitA && !chained;
        bBreak = 1'b0;
        if (chained) begin
            if (hitA) begin
                state_d.chainArmed = 1'b1;
            end
            if (bQualified) begin
                state_d.chainArmed = 1'b0;
            end
        end else begin
            state_d.chainArmed = 1'b0;
        end
        if (bQualified) begin
            if (countEn) begin
                // Break on the match seen while the count already sits at one.
                if (state_q.matchCount == bcl_pkg::COUNT_ONE) begin
                    bBreak = 1'b1;
                end
                if (state_q.matchCount != '0) begin
                    state_d.matchCount = state_q.matchCount - bcl_pkg::COUNT_ONE;
                end
            end else begin
                bBreak = 1'b1;
            end
        end
        aBreak = aBreak && !state_q.breakControl[bcl_pkg::UBID_A_BIT];
        bBreak = bBreak && !state_q.breakControl[bcl_pkg::UBID_B_BIT];
        irqSet = {bBreak, aBreak};
        state_d.userBreak = aBreak || bBreak;

        // Register writes; hardware sets win over software clears.
        if (wr) begin
            case (paddr)
                bcl_pkg::BREAK_CONTROL_OFS: begin
                    state_d.breakControl = pwdata & bcl_pkg::BREAK_CONTROL_WMASK;
                end
                bcl_pkg::MATCH_COUNT_OFS: begin
                    state_d.matchCount = pwdata[11:0];
                end
                bcl_pkg::IRQ_STATUS_OFS: begin
                    state_d.irqStatus = state_q.irqStatus & ~pwdata[1:0];
                end
                bcl_pkg::IRQ_MASK_OFS: begin
                    state_d.irqMask = pwdata[1:0];
                end
                bcl_pkg::CHAN_A_ADDR_OFS: begin
                    state_d.cmpA.addr = pwdata;
                end
                bcl_pkg::CHAN_A_DATA_OFS: begin
                    state_d.cmpA.data = pwdata;
                end
                bcl_pkg::CHAN_B_ADDR_OFS: begin
                    state_d.cmpB.addr = pwdata;
                end
                bcl_pkg::CHAN_B_DATA_OFS: begin
                    state_d.cmpB.data = pwdata;
                end
                default: begin
                    state_d.slverr = 1'b1;
                end
            endcase
        end
        if (setFlagB) begin
            state_d.breakControl[bcl_pkg::MATCH_FLAG_B_BIT] = 1'b1;
        end
        state_d.irqStatus = state_d.irqStatus | irqSet;
        state_d.irq = |(state_d.irqStatus & state_d.irqMask);

        // Read data is captured in the first access cycle, the wait state.
        state_d.rdata = '0;
        if (access && !pwrite) begin
            case (paddr)
                bcl_pkg::BREAK_CONTROL_OFS: begin
                    state_d.rdata = state_q.breakControl;
                end
                bcl_pkg::MATCH_COUNT_OFS: begin
                    state_d.rdata = {20'h0_0000, state_q.matchCount};
                end
                bcl_pkg::IRQ_STATUS_OFS: begin
                    state_d.rdata = {30'h0, state_q.irqStatus};
                end
                bcl_pkg::IRQ_MASK_OFS: begin
                    state_d.rdata = {30'h0, state_q.irqMask};
                end
                bcl_pkg::CHAN_A_ADDR_OFS: begin
                    state_d.rdata = state_q.cmpA.addr;
                end
                bcl_pkg::CHAN_A_DATA_OFS: begin
                    state_d.rdata = state_q.cmpA.data;
                end
                bcl_pkg::CHAN_B_ADDR_OFS: begin
                    state_d.rdata = state_q.cmpB.addr;
                end
                bcl_pkg::CHAN_B_DATA_OFS: begin
                    state_d.rdata = state_q.cmpB.data;
                end
                default: begin
                    state_d.slverr = 1'b1;
                end
            endcase
        end

        if (!rst_b) begin
            state_d = '0;
            state_d.breakControl = bcl_pkg::BREAK_CONTROL_RST;
            state_d.matchCount = bcl_pkg::MATCH_COUNT_RST;
        end
    end

    always_ff @(posedge clk) begin
        state_q <= state_d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = state_q.rdata;
    assign pready = state_q.ready;
    assign pslverr = state_q.slverr;
    assign userBreak = state_q.userBreak;
    assign branchTraceEn = state_q.breakControl[bcl_pkg::TRACE_EN_BIT];
    assign irq = state_q.irq;
endmodule

// ---- bcl_pkg.sv ----
// Package with register map, field positions and carrier types of the break control block.
package bcl_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] BREAK_CONTROL_OFS = 8'h00;
    localparam logic [7:0] MATCH_COUNT_OFS = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
    localparam logic [7:0] CHAN_A_ADDR_OFS = 8'h10;
    localparam logic [7:0] CHAN_A_DATA_OFS = 8'h14;
    localparam logic [7:0] CHAN_B_ADDR_OFS = 8'h18;
    localparam logic [7:0] CHAN_B_DATA_OFS = 8'h1c;

    // ****************************************************************
    // Break control fields
    // ****************************************************************
    localparam int UBID_B_BIT = 19;
    localparam int UBID_A_BIT = 17;
    localparam int MATCH_FLAG_B_BIT = 12;
    localparam int TRACE_EN_BIT = 11;
    localparam int TIMING_A_BIT = 10;
    localparam int DATA_EN_A_BIT = 7;
    localparam int TIMING_B_BIT = 6;
    localparam int DATA_EN_B_BIT = 5;
    localparam int CHAINED_BIT = 3;
    localparam int COUNT_EN_BIT = 0;
    localparam logic [31:0] BREAK_CONTROL_WMASK = 32'h000a_1ce9;
    localparam logic [31:0] BREAK_CONTROL_RST = 32'h0000_0000;
    localparam logic [11:0] MATCH_COUNT_RST = 12'h000;
    localparam logic [11:0] COUNT_ONE = 12'h001;

    // Interrupt status bits: 0 break A, 1 break B.
    localparam int IRQ_BITS = 2;
    localparam logic [1:0] IRQ_RST = 2'h0;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic fetch;
        logic [31:0] addr;
        logic [31:0] data;
    } bcl_bus_cycle_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } bcl_cmp_s;

endpackage

// ---- bcl_chan_match.sv ----
// One channel comparator with fetch timing and optional data compare.
`timescale 1ns/1ps
module bcl_chan_match (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Settings
    input wire bcl_pkg::bcl_cmp_s cmpVal,
    input wire logic dataEn,
    input wire logic timingAfter,
    // Core bus
    input wire bcl_pkg::bcl_bus_cycle_s cyc,
    input wire logic fetchRetire,
    // Result
    output logic hit
);
    typedef struct packed {
        logic pending;
        logic hit;
    } bcl_chan_state_s;

    bcl_chan_state_s state_q;
    bcl_chan_state_s state_d;
    logic cond;

    always_comb begin
        cond = cyc.valid && (cyc.addr == cmpVal.addr) &&
               (!dataEn || (cyc.data == cmpVal.data));
        state_d = state_q;
        state_d.hit = 1'b0;
        if (cyc.fetch && timingAfter) begin
            // An after-execution break waits until the core retires the fetched instruction.
            if (cond) begin
                state_d.pending = 1'b1;
            end
        end else begin
            state_d.hit = cond;
        end
        if (state_q.pending && fetchRetire) begin
            state_d.hit = 1'b1;
            state_d.pending = cond && cyc.fetch && timingAfter;
        end
        if (!rst_b) begin
            state_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        state_q <= state_d;
    end

    assign hit = state_q.hit;
endmodule

// ---- bcl_break_control_checker.sv ----
// Concurrent checks on the ports of the break controller.
`timescale 1ns/1ps
module bcl_break_control_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Core and break side
    input wire bcl_pkg::bcl_bus_cycle_s busCycle,
    input wire logic fetchRetire,
    input wire logic userBreak,
    input wire logic branchTraceEn,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic ctlWr;
    assign ctlWr = psel && penable && pwrite && paddr == bcl_pkg::BREAK_CONTROL_OFS;
    // **********
    // Assertions
    // **********
    AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("apb access not answered after one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("slave error without ready or with data");
    AST_RSV_ZERO: assert property (pready && !pwrite && paddr == 8'h00 |->
        prdata[31:20] == 12'h0 && !prdata[18] && !prdata[16] && prdata[9:8] == 2'h0
        && !prdata[4] && prdata[2:1] == 2'h0) else $error("reserved control bit reads 1");
    AST_BREAK_PULSE: assert property (userBreak |=> !userBreak)
        else $error("user break longer than one cycle");
    AST_BREAK_CAUSE: assert property (userBreak |->
        $past(busCycle.valid, 2) || $past(fetchRetire, 2)) else $error("break without cause");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> userBreak ||
        $past(psel && pwrite) || $past(psel && pwrite, 2)) else $error("irq rose without cause");
    AST_TRACE_SRC: assert property ($changed(branchTraceEn) |->
        $past(ctlWr) || $past(ctlWr, 2)) else $error("trace enable changed without write");
    AST_RESET_CLEAR: assert property (disable iff (1'b0) !rst_b |=>
        !userBreak && !irq && !pready && !branchTraceEn) else $error("outputs not cleared");
    cover property (userBreak);
    cover property (pslverr);
    cover property ($fell(irq));
endmodule
bind bcl_break_control bcl_break_control_checker chk (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busCycle(busCycle), .fetchRetire(fetchRetire),
    .userBreak(userBreak), .branchTraceEn(branchTraceEn), .irq(irq));

// ---- bcl_core_model.sv ----
// Behavioural processor core that issues bus cycles and retire pulses.
`timescale 1ns/1ps
module bcl_core_model (
    // Clock
    input wire logic clk,
    // Core bus
    output bcl_pkg::bcl_bus_cycle_s busCycle,
    output logic fetchRetire
);
    initial begin
        busCycle = '0;
        fetchRetire = 1'b0;
    end
    // Idle address and data lines carry the inverse of the last cycle so a stale value never matches.
    task automatic cycle(input logic f, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        busCycle <= {1'b1, f, a, d};
        @(posedge clk);
        busCycle <= {1'b0, f, ~a, ~d};
    endtask
    task automatic retire();
        @(posedge clk);
        fetchRetire <= 1'b1;
        @(posedge clk);
        fetchRetire <= 1'b0;
    endtask
endmodule

// ---- bcl_break_control_tb_top.sv ----
// Self-checking bench for the break controller.
`timescale 1ns/1ps
module bcl_break_control_tb_top;
    logic clk;
    logic rst_b;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    bcl_pkg::bcl_bus_cycle_s busCycle;
    logic fetchRetire;
    logic userBreak;
    logic branchTraceEn;
    logic irq;
    logic [31:0] rd;
    logic err;
    int failCount;
    int checked;

    always #20 clk = ~clk;

    bcl_core_model core (.clk(clk), .busCycle(busCycle), .fetchRetire(fetchRetire));
    bcl_break_control uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busCycle(busCycle), .fetchRetire(fetchRetire),
        .userBreak(userBreak), .branchTraceEn(branchTraceEn), .irq(irq));

    // ***********
    // Bench tasks
    // ***********
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            failCount++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // A break shows two cycles after its cause, so five cycles is a full window.
    task automatic obs(input string nm, input logic e);
        logic seen;
        seen = 1'b0;
        repeat (5) begin
            @(posedge clk);
            seen = seen | userBreak;
        end
        chk(nm, {31'h0, e}, {31'h0, seen});
    endtask
    task automatic hit(input string nm, input logic f, input logic [31:0] a,
        input logic [31:0] d, input logic e);
        core.cycle(f, a, d);
        obs(nm, e);
    endtask

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rdc("control reset", 8'h00, 32'h0);
        rdc("count reset", 8'h04, 32'h0);
        wr(8'h00, 32'h000a_0ce9);
        rdc("control rw", 8'h00, 32'h000a_0ce9);
        chk("trace on", 32'h1, branchTraceEn);
        wr(8'h00, 32'h0);
        chk("trace off", 32'h0, branchTraceEn);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, err);
        wr(8'h10, 32'h200);
        wr(8'h14, 32'h0);
        wr(8'h18, 32'h100);
        wr(8'h1c, 32'h55);
        wr(8'h0c, 32'h3);
        hit("b break", 1'b1, 32'h100, 32'h0, 1'b1);
        rdc("b flag", 8'h00, 32'h1000);
        rdc("status", 8'h08, 32'h2);
        wr(8'h0c, 32'h0);
        @(posedge clk);
        chk("irq masked", 32'h0, irq);
        wr(8'h0c, 32'h3);
        @(posedge clk);
        chk("irq raised", 32'h1, irq);
        wr(8'h08, 32'h2);
        @(posedge clk);
        chk("irq cleared", 32'h0, irq);
        wr(8'h00, 32'h0);
        rdc("flag clear", 8'h00, 32'h0);
        hit("a break", 1'b1, 32'h200, 32'h0, 1'b1);
        wr(8'h00, 32'h20);
        hit("b data miss", 1'b0, 32'h100, 32'h66, 1'b0);
        hit("b data hit", 1'b0, 32'h100, 32'h55, 1'b1);
        wr(8'h00, 32'h80);
        hit("a data miss", 1'b0, 32'h200, 32'h66, 1'b0);
        hit("a data hit", 1'b0, 32'h200, 32'h0, 1'b1);
        wr(8'h00, 32'h0008_0000);
        hit("b disabled", 1'b1, 32'h100, 32'h0, 1'b0);
        rdc("flag kept", 8'h00, 32'h0008_1000);
        wr(8'h00, 32'h0002_0000);
        hit("a disabled", 1'b1, 32'h200, 32'h0, 1'b0);
        wr(8'h00, 32'h8);
        hit("chain b first", 1'b1, 32'h100, 32'h0, 1'b0);
        hit("chain a", 1'b1, 32'h200, 32'h0, 1'b0);
        hit("chain b", 1'b1, 32'h100, 32'h0, 1'b1);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h1);
        hit("count two", 1'b1, 32'h100, 32'h0, 1'b0);
        hit("count one", 1'b1, 32'h100, 32'h0, 1'b1);
        hit("count zero", 1'b1, 32'h100, 32'h0, 1'b0);
        rdc("count end", 8'h04, 32'h0);
        wr(8'h00, 32'h40);
        hit("b fetch", 1'b1, 32'h100, 32'h0, 1'b0);
        core.retire();
        obs("b retire", 1'b1);
        wr(8'h00, 32'h400);
        hit("a fetch", 1'b1, 32'h200, 32'h0, 1'b0);
        core.retire();
        obs("a retire", 1'b1);
        report_and_stop();
    end
endmodule
